// ==== src/psld_driver.sv ====
// Port status lamp driver: resolves port state onto two bicolour lamps
//
// Operation
// - Two red/green lamps per port, each showing one of four patterns.
// - Blink toggles at a fixed rate from a free-running clock divider.
// - Activity pattern switches the lamp from a pseudo-random shift register.
// - No open session keeps both lamps dark unless identify or fatal error.
// - Session, power, no traffic: first lamp solid green, second off.
// - Session open without bus power: first lamp solid red, second off.
// - Traffic with error-active controller, or LIN traffic: green activity.
// - Traffic with error-passive controller: green first, red activity second.
// - Activity ends one second after last frame; each frame restarts it.
// - Bus-off on a running CAN port: solid green first, solid red second.
// - FlexRay normal-active: green activity continues with no timeout.
// - FlexRay normal-passive: red activity continues while integrated.
// - FlexRay halt after integration: solid green first, solid red second.
`timescale 1ns/100ps
`include "psld_regs.svh"

module psld_driver import psld_pkg::*; #(
  parameter int BLINK_HALF_CYC =
    `PSLD_BLINK_HALF_MS * `PSLD_CYC_PER_MS,
  parameter int ACT_STEP_CYC =
    `PSLD_ACT_STEP_MS * `PSLD_CYC_PER_MS,
  parameter int IDLE_TIMEOUT_CYC =
    `PSLD_IDLE_TIMEOUT_MS * `PSLD_CYC_PER_MS
) (
  input wire clk_i,                    // Board clock, 100 MHz
  input wire rst_i,                    // Asynchronous reset, active high
  input wire session_open_i,           // A session is open on the port
  input wire port_power_i,             // Port bus power present
  input wire identify_i,               // Port identification request
  input wire cat_error_i,              // Catastrophic error indication
  input psld_proto_t protocol_i,       // Protocol of this port
  input psld_ctrl_t ctrl_state_i,      // CAN controller fault state
  input psld_fr_t fr_state_i,          // FlexRay controller state
  input wire frame_event_i,            // Pulse per frame sent or received
  output logic session_status_lamp_red_o,   // First lamp, red
  output logic session_status_lamp_green_o, // First lamp, green
  output logic bus_activity_lamp_red_o,     // Second lamp, red
  output logic bus_activity_lamp_green_o    // Second lamp, green
);

  // ----------------------------------------------------------------------
  // Pattern sources
  // ----------------------------------------------------------------------
  logic blink;
  logic act;

  // Fixed-rate blink phase
  psld_blink_gen #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .blink_o(blink)
  );

  // Pseudo-random activity phase
  psld_activity_gen #(
    .STEP_CYC(ACT_STEP_CYC)
  ) u_act (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .act_o(act)
  );

  // ----------------------------------------------------------------------
  // Lamp pattern evaluation
  // ----------------------------------------------------------------------
  // Whether a lamp with the given pattern is lit this cycle
  function automatic logic lamp_lit(input psld_pat_t pat,
                                    input logic blink_ph,
                                    input logic act_ph);
    logic lit;
    lit = 1'b0;
    unique case (pat)
      PAT_OFF: lit = 1'b0;
      PAT_SOLID: lit = 1'b1;
      PAT_BLINK: lit = blink_ph;
      PAT_ACTIVITY: lit = act_ph;
    endcase
    return lit;
  endfunction : lamp_lit

  // ----------------------------------------------------------------------
  // Idle timeout
  // ----------------------------------------------------------------------
  logic [`PSLD_CNT_W-1:0] idle_cnt;
  logic [`PSLD_CNT_W-1:0] next_idle_cnt;
  logic communicating;

  // Reload on every frame, count down to zero, clear when session closes
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (!session_open_i) begin
      next_idle_cnt = '0;
    end else if (frame_event_i) begin
      next_idle_cnt = `PSLD_CNT_W'(IDLE_TIMEOUT_CYC);
    end else if (idle_cnt != '0) begin
      next_idle_cnt = idle_cnt - `PSLD_CNT_W'(1);
    end
  end

  // Register the timeout counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end

  assign communicating = (idle_cnt != '0);

  // ----------------------------------------------------------------------
  // FlexRay integration memory
  // ----------------------------------------------------------------------
  logic fr_was_int;
  logic next_fr_was_int;

  // Remember integration so a later halt reads as a fault
  always_comb begin
    next_fr_was_int = fr_was_int;
    if (!session_open_i || protocol_i != PROTO_FLEXRAY) begin
      next_fr_was_int = 1'b0;
    end else if (fr_state_i == FR_NORMAL_ACTIVE ||
                 fr_state_i == FR_NORMAL_PASSIVE) begin
      next_fr_was_int = 1'b1;
    end
  end

  // Register the integration flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fr_was_int <= 1'b0;
    end else begin
      fr_was_int <= next_fr_was_int;
    end
  end

  // ----------------------------------------------------------------------
  // Display state resolution
  // ----------------------------------------------------------------------
  psld_disp_t disp;
  psld_disp_t next_disp;

  // Fixed priority from highest to lowest
  always_comb begin
    next_disp = DISP_IDLE;
    if (cat_error_i) begin
      next_disp = DISP_CAT_ERR;
    end else if (identify_i) begin
      next_disp = DISP_IDENT;
    end else if (!session_open_i) begin
      next_disp = DISP_DARK;
    end else if (!port_power_i) begin
      next_disp = DISP_NO_POWER;
    end else begin
      case (protocol_i)
        PROTO_FLEXRAY: begin
          unique case (fr_state_i)
            FR_NORMAL_ACTIVE: next_disp = DISP_ACT_GREEN;
            FR_NORMAL_PASSIVE: next_disp = DISP_ACT_RED;
            FR_HALT: next_disp = fr_was_int ? DISP_FAULT : DISP_IDLE;
            FR_NOT_INTEGRATED: next_disp = DISP_IDLE;
          endcase
        end
        PROTO_LIN: begin
          if (communicating) begin
            next_disp = DISP_ACT_GREEN;
          end
        end
        default: begin
          if (ctrl_state_i == CTRL_BUS_OFF) begin
            next_disp = DISP_FAULT;
          end else if (communicating) begin
            next_disp = (ctrl_state_i == CTRL_ERR_PASSIVE) ?
                        DISP_ACT_RED : DISP_ACT_GREEN;
          end else begin
            next_disp = DISP_IDLE;
          end
        end
      endcase
    end
  end

  // Register the display state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      disp <= DISP_DARK;
    end else begin
      disp <= next_disp;
    end
  end

  // ----------------------------------------------------------------------
  // Lamp outputs
  // ----------------------------------------------------------------------
  psld_pat_t ses_pat;
  psld_pat_t bus_pat;
  logic ses_red;
  logic bus_red;
  logic ses_on;
  logic bus_on;
  logic next_ses_red;
  logic next_ses_green;
  logic next_bus_red;
  logic next_bus_green;

  // Map display state to a pattern and colour for each lamp
  always_comb begin
    ses_pat = PAT_OFF;
    bus_pat = PAT_OFF;
    ses_red = 1'b0;
    bus_red = 1'b0;
    unique case (disp)
      DISP_DARK: begin
        ses_pat = PAT_OFF;
      end
      DISP_IDENT: begin
        ses_pat = PAT_BLINK;
        bus_pat = PAT_BLINK;
      end
      DISP_CAT_ERR: begin
        ses_pat = PAT_BLINK;
        bus_pat = PAT_BLINK;
        ses_red = 1'b1;
        bus_red = 1'b1;
      end
      DISP_NO_POWER: begin
        ses_pat = PAT_SOLID;
        ses_red = 1'b1;
      end
      DISP_FAULT: begin
        ses_pat = PAT_SOLID;
        bus_pat = PAT_SOLID;
        bus_red = 1'b1;
      end
      DISP_ACT_GREEN: begin
        ses_pat = PAT_SOLID;
        bus_pat = PAT_ACTIVITY;
      end
      DISP_ACT_RED: begin
        ses_pat = PAT_SOLID;
        bus_pat = PAT_ACTIVITY;
        bus_red = 1'b1;
      end
      DISP_IDLE: begin
        ses_pat = PAT_SOLID;
      end
    endcase
    ses_on = lamp_lit(ses_pat, blink, act);
    bus_on = lamp_lit(bus_pat, blink, act);
    next_ses_red = ses_on & ses_red;
    next_ses_green = ses_on & ~ses_red;
    next_bus_red = bus_on & bus_red;
    next_bus_green = bus_on & ~bus_red;
  end

  // Register the lamp drives
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      session_status_lamp_red_o <= 1'b0;
      session_status_lamp_green_o <= 1'b0;
      bus_activity_lamp_red_o <= 1'b0;
      bus_activity_lamp_green_o <= 1'b0;
    end else begin
      session_status_lamp_red_o <= next_ses_red;
      session_status_lamp_green_o <= next_ses_green;
      bus_activity_lamp_red_o <= next_bus_red;
      bus_activity_lamp_green_o <= next_bus_green;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Port open and powered with no override active
  sequence s_open_powered;
    session_open_i && port_power_i && !identify_i && !cat_error_i;
  endsequence

  // Quiet CAN port in one cycle, then one more cycle for the first pipeline stage
  sequence s_quiet_can;
    (s_open_powered and protocol_i == PROTO_CAN &&
     ctrl_state_i == CTRL_ERR_ACTIVE && !communicating &&
     !frame_event_i) ##1 1'b1;
  endsequence

  a_one_colour: assert property (
    !(session_status_lamp_red_o && session_status_lamp_green_o) &&
    !(bus_activity_lamp_red_o && bus_activity_lamp_green_o))
    else $error("lamp driven red and green together");

  a_dark_closed: assert property (
    (!session_open_i && !identify_i && !cat_error_i) |-> ##2
    !session_status_lamp_red_o && !session_status_lamp_green_o &&
    !bus_activity_lamp_red_o && !bus_activity_lamp_green_o)
    else $error("lamps lit with no session");

  a_idle_green: assert property (
    s_quiet_can |-> ##1 session_status_lamp_green_o &&
    !bus_activity_lamp_red_o && !bus_activity_lamp_green_o)
    else $error("powered idle port not solid green");

  a_no_power_red: assert property (
    (session_open_i && !port_power_i && !identify_i && !cat_error_i)
    |-> ##1 disp == DISP_NO_POWER ##1 session_status_lamp_red_o &&
    !bus_activity_lamp_red_o && !bus_activity_lamp_green_o)
    else $error("unpowered port not solid red");

  a_act_green: assert property (
    disp == DISP_ACT_GREEN |=> session_status_lamp_green_o &&
    !bus_activity_lamp_red_o && bus_activity_lamp_green_o == $past(act))
    else $error("green activity pattern wrong");

  a_act_red: assert property (
    disp == DISP_ACT_RED |=> session_status_lamp_green_o &&
    !bus_activity_lamp_green_o && bus_activity_lamp_red_o == $past(act))
    else $error("red activity pattern wrong");

  a_idle_reload: assert property (
    (session_open_i && frame_event_i) |=>
    idle_cnt == `PSLD_CNT_W'(IDLE_TIMEOUT_CYC) ##1
    ($past(frame_event_i) || !$past(session_open_i) ||
     idle_cnt == `PSLD_CNT_W'(IDLE_TIMEOUT_CYC - 1)))
    else $error("idle timer not restarted by frame");

  a_bus_off: assert property (
    (s_open_powered and protocol_i == PROTO_CAN &&
     ctrl_state_i == CTRL_BUS_OFF) |-> ##2
    session_status_lamp_green_o && bus_activity_lamp_red_o)
    else $error("bus-off not shown");

  a_fr_active: assert property (
    (s_open_powered and protocol_i == PROTO_FLEXRAY &&
     fr_state_i == FR_NORMAL_ACTIVE) |=> disp == DISP_ACT_GREEN)
    else $error("normal-active activity missing");

  a_fr_passive: assert property (
    (s_open_powered and protocol_i == PROTO_FLEXRAY &&
     fr_state_i == FR_NORMAL_PASSIVE) |=> disp == DISP_ACT_RED)
    else $error("normal-passive activity missing");

  a_fr_halt: assert property (
    (s_open_powered and protocol_i == PROTO_FLEXRAY &&
     fr_state_i == FR_HALT && fr_was_int) |=> disp == DISP_FAULT)
    else $error("halt after integration not shown");

  a_ident_blink: assert property (
    disp == DISP_IDENT |=> !session_status_lamp_red_o &&
    session_status_lamp_green_o == $past(blink) &&
    bus_activity_lamp_green_o == $past(blink))
    else $error("identify blink wrong");

  a_fatal_first: assert property (
    cat_error_i |=> disp == DISP_CAT_ERR)
    else $error("fatal error did not take priority");

endmodule : psld_driver

// ==== src/psld_regs.svh ====
// Timing constants and seeds for the port status lamp driver
`ifndef PSLD_REGS_SVH
`define PSLD_REGS_SVH

// ----------------------------------------------------------------------
// Clock rate
// ----------------------------------------------------------------------
`define PSLD_CLK_MHZ 100
`define PSLD_CYC_PER_MS (`PSLD_CLK_MHZ * 1000)

// ----------------------------------------------------------------------
// Display timing in milliseconds
// ----------------------------------------------------------------------
`define PSLD_BLINK_HALF_MS 125
`define PSLD_ACT_STEP_MS 40
`define PSLD_IDLE_TIMEOUT_MS 1000

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define PSLD_CNT_W 32
`define PSLD_LFSR_W 16
`define PSLD_LFSR_SEED 16'hACE1
`define PSLD_LFSR_TAPS 16'hB400

`endif

// ==== src/psld_pkg.sv ====
// Types shared by the port status lamp driver modules
package psld_pkg;

  // Protocol of the port
  typedef enum logic [1:0] {
    PROTO_CAN     = 2'b00,
    PROTO_FLEXRAY = 2'b01,
    PROTO_LIN     = 2'b10
  } psld_proto_t;

  // Fault confinement state of a CAN controller
  typedef enum logic [1:0] {
    CTRL_ERR_ACTIVE  = 2'b00,
    CTRL_ERR_PASSIVE = 2'b01,
    CTRL_BUS_OFF     = 2'b10
  } psld_ctrl_t;

  // FlexRay controller state
  typedef enum logic [1:0] {
    FR_NOT_INTEGRATED = 2'b00,
    FR_NORMAL_ACTIVE  = 2'b01,
    FR_NORMAL_PASSIVE = 2'b10,
    FR_HALT           = 2'b11
  } psld_fr_t;

  // Lamp display pattern
  typedef enum logic [1:0] {
    PAT_OFF      = 2'b00,
    PAT_SOLID    = 2'b01,
    PAT_BLINK    = 2'b10,
    PAT_ACTIVITY = 2'b11
  } psld_pat_t;

  // Resolved port display state
  typedef enum logic [2:0] {
    DISP_DARK      = 3'b000,
    DISP_IDENT     = 3'b001,
    DISP_CAT_ERR   = 3'b010,
    DISP_NO_POWER  = 3'b011,
    DISP_FAULT     = 3'b100,
    DISP_ACT_GREEN = 3'b101,
    DISP_ACT_RED   = 3'b110,
    DISP_IDLE      = 3'b111
  } psld_disp_t;

endpackage : psld_pkg

// ==== src/psld_blink_gen.sv ====
// Free-running divider that makes the fixed-rate blink phase
`timescale 1ns/100ps
`include "psld_regs.svh"

module psld_blink_gen import psld_pkg::*; #(
  parameter int HALF_CYC = 1000
) (
  input wire clk_i,   // Board clock
  input wire rst_i,   // Asynchronous reset, active high
  output logic blink_o // Blink phase, toggles every HALF_CYC cycles
);

  logic [`PSLD_CNT_W-1:0] cnt;
  logic [`PSLD_CNT_W-1:0] next_cnt;
  logic next_blink;

  // Count cycles and toggle the phase at the end of each half period
  always_comb begin
    next_cnt = cnt + `PSLD_CNT_W'(1);
    next_blink = blink_o;
    if (cnt >= `PSLD_CNT_W'(HALF_CYC - 1)) begin
      next_cnt = '0;
      next_blink = ~blink_o;
    end
  end

  // Register divider state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      blink_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      blink_o <= next_blink;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_blink_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(blink_o) |-> $past(cnt) == `PSLD_CNT_W'(HALF_CYC - 1))
    else $error("blink phase toggled off its period");

endmodule : psld_blink_gen

// ==== src/psld_activity_gen.sv ====
// Pseudo-random on/off source for the activity pattern
`timescale 1ns/100ps
`include "psld_regs.svh"

module psld_activity_gen import psld_pkg::*; #(
  parameter int STEP_CYC = 1000
) (
  input wire clk_i,  // Board clock
  input wire rst_i,  // Asynchronous reset, active high
  output logic act_o // Pseudo-random lamp phase
);

  logic [`PSLD_CNT_W-1:0] cnt;
  logic [`PSLD_CNT_W-1:0] next_cnt;
  logic [`PSLD_LFSR_W-1:0] lfsr;
  logic [`PSLD_LFSR_W-1:0] next_lfsr;
  logic next_act;

  // Step a Galois shift register once per step period
  always_comb begin
    next_cnt = cnt + `PSLD_CNT_W'(1);
    next_lfsr = lfsr;
    next_act = act_o;
    if (cnt >= `PSLD_CNT_W'(STEP_CYC - 1)) begin
      next_cnt = '0;
      next_lfsr = {1'b0, lfsr[`PSLD_LFSR_W-1:1]} ^
                  (lfsr[0] ? `PSLD_LFSR_TAPS : '0);
      next_act = lfsr[0];
    end
  end

  // Register generator state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      lfsr <= `PSLD_LFSR_SEED;
      act_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      lfsr <= next_lfsr;
      act_o <= next_act;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_lfsr_alive: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(act_o) |-> $past(cnt) == `PSLD_CNT_W'(STEP_CYC - 1) &&
      lfsr != '0)
    else $error("activity source stepped off period or locked up");

endmodule : psld_activity_gen

// ==== sim/psld_lamp_model.sv ====
// Model of one bicolour indicator lamp on the board front
`timescale 1ns/100ps

module psld_lamp_model (
  input wire clk_i,           // Board clock
  input wire red_i,           // Red drive, high = lit
  input wire green_i,         // Green drive, high = lit
  output logic [1:0] shade_o, // 0 dark, 1 green, 2 red, 3 both
  output logic clash_o        // Sticky: both colours were lit at once
);
  // -------------------------------------------------------------------
  // Colour seen by the user
  // -------------------------------------------------------------------
  assign shade_o = {red_i, green_i};

  // A two-colour lamp shows one colour; both driven is a fault
  initial clash_o = 1'b0;
  always @(posedge clk_i) begin
    if (red_i && green_i) begin
      clash_o <= 1'b1;
    end
  end
endmodule : psld_lamp_model

// ==== sim/tb.sv ====
// Self-checking bench for the port status lamp driver
`timescale 1ns/100ps

module tb import psld_pkg::*; ;
  localparam int BLINK_HALF = 4;
  localparam int WIN = 48;
  localparam logic Y = 1'b1;
  localparam logic N = 1'b0;

  logic clk_i, rst_i, sess, pwr, ident, cat, frame;
  psld_proto_t proto;
  psld_ctrl_t ctrl;
  psld_fr_t fr;
  logic s_red, s_grn, b_red, b_grn, s_clash, b_clash;
  logic [1:0] s_shade, b_shade;
  int err_count = 0;
  int n_tests = 0;

  // -------------------------------------------------------------------
  // Design and lamp models
  // -------------------------------------------------------------------
  psld_driver #(
    .BLINK_HALF_CYC(BLINK_HALF),
    .ACT_STEP_CYC(3),
    .IDLE_TIMEOUT_CYC(20)
  ) u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .session_open_i(sess),
    .port_power_i(pwr),
    .identify_i(ident),
    .cat_error_i(cat),
    .protocol_i(proto),
    .ctrl_state_i(ctrl),
    .fr_state_i(fr),
    .frame_event_i(frame),
    .session_status_lamp_red_o(s_red),
    .session_status_lamp_green_o(s_grn),
    .bus_activity_lamp_red_o(b_red),
    .bus_activity_lamp_green_o(b_grn)
  );
  psld_lamp_model u_sess_lamp (.clk_i(clk_i), .red_i(s_red),
    .green_i(s_grn), .shade_o(s_shade), .clash_o(s_clash));
  psld_lamp_model u_bus_lamp (.clk_i(clk_i), .red_i(b_red),
    .green_i(b_grn), .shade_o(b_shade), .clash_o(b_clash));

  // Board clock, 100 MHz
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // -------------------------------------------------------------------
  // Compare and verdict
  // -------------------------------------------------------------------
  task automatic cmp_pat(input psld_pat_t got, input psld_pat_t exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t pattern %s exp %s", $time, got.name(),
        exp.name());
    end
  endtask : cmp_pat

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // -------------------------------------------------------------------
  // Stimulus and observation helpers
  // -------------------------------------------------------------------
  // Apply a port state, then let the two-cycle latency pass
  task automatic drive(input logic s, input logic p, input logic i,
      input logic c, input psld_proto_t pr, input psld_ctrl_t ct,
      input psld_fr_t f, input logic fe);
    @(posedge clk_i);
    sess <= s;
    pwr <= p;
    ident <= i;
    cat <= c;
    proto <= pr;
    ctrl <= ct;
    fr <= f;
    frame <= fe;
    repeat (4) @(posedge clk_i);
  endtask : drive

  // Classify one lamp over n cycles; blink has runs of exactly BLINK_HALF
  task automatic observe(input logic bus, input logic red, input int n,
      output psld_pat_t pat, output logic stray);
    logic [1:0] want, sh;
    logic lit, prev;
    int on, chg, run, irreg;
    want = red ? 2'b10 : 2'b01;
    stray = N;
    prev = N;
    on = 0;
    chg = 0;
    run = 0;
    irreg = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      sh = bus ? b_shade : s_shade;
      lit = (sh === want);
      if (sh !== 2'b00 && !lit) stray = Y;
      if (lit) on++;
      if (i > 0 && lit != prev) begin
        if (chg > 0 && run != BLINK_HALF) irreg = 1;
        chg++;
        run = 0;
      end
      run++;
      prev = lit;
    end
    if (on == 0) pat = PAT_OFF;
    else if (on == n) pat = PAT_SOLID;
    else if (irreg == 0 && chg >= 2) pat = PAT_BLINK;
    else pat = PAT_ACTIVITY;
  endtask : observe

  // Judge both lamps against pattern and colour (red when flag set)
  task automatic expect_lamps(input psld_pat_t sp, input logic sr,
      input psld_pat_t bp, input logic br);
    psld_pat_t p1, p2;
    logic st1, st2;
    fork
      observe(N, sr, WIN, p1, st1);
      observe(Y, br, WIN, p2, st2);
    join
    cmp_pat(p1, sp);
    cmp_bit(st1, N);
    cmp_pat(p2, bp);
    cmp_bit(st2, N);
  endtask : expect_lamps

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_dark();
    drive(N, Y, N, N, PROTO_CAN, CTRL_BUS_OFF, FR_NOT_INTEGRATED, Y);
    expect_lamps(PAT_OFF, N, PAT_OFF, N);
  endtask : t_dark

  task automatic t_override();
    drive(N, N, Y, N, PROTO_CAN, CTRL_ERR_ACTIVE, FR_NOT_INTEGRATED, N);
    expect_lamps(PAT_BLINK, N, PAT_BLINK, N);
    drive(Y, Y, Y, Y, PROTO_CAN, CTRL_BUS_OFF, FR_NOT_INTEGRATED, Y);
    expect_lamps(PAT_BLINK, Y, PAT_BLINK, Y);
  endtask : t_override

  task automatic t_power();
    drive(Y, Y, N, N, PROTO_CAN, CTRL_ERR_ACTIVE, FR_NOT_INTEGRATED, N);
    // Let the timer armed by the earlier frames run out
    repeat (20) @(posedge clk_i);
    expect_lamps(PAT_SOLID, N, PAT_OFF, N);
    drive(Y, N, N, N, PROTO_CAN, CTRL_BUS_OFF, FR_NOT_INTEGRATED, Y);
    expect_lamps(PAT_SOLID, Y, PAT_OFF, N);
  endtask : t_power

  // Frames at 0,18,36,54: lamp must stay on past the first timeout
  task automatic t_timeout();
    int lit;
    drive(Y, Y, N, N, PROTO_CAN, CTRL_ERR_ACTIVE, FR_NOT_INTEGRATED, N);
    lit = 0;
    for (int i = 0; i < 102; i++) begin
      @(posedge clk_i);
      frame <= (i % 18 == 0 && i < 72);
      #1;
      if (i >= 25 && i <= 77 && b_shade === 2'b01) lit++;
      if (i >= 79) cmp_bit(b_shade === 2'b00, Y);
    end
    cmp_bit(lit > 0, Y);
  endtask : t_timeout

  task automatic t_can();
    psld_ctrl_t cs[3] = '{CTRL_ERR_ACTIVE, CTRL_ERR_PASSIVE, CTRL_BUS_OFF};
    psld_pat_t bp[3] = '{PAT_ACTIVITY, PAT_ACTIVITY, PAT_SOLID};
    logic br[3] = '{N, Y, Y};
    for (int k = 0; k < 3; k++) begin
      drive(Y, Y, N, N, PROTO_CAN, cs[k], FR_NOT_INTEGRATED, Y);
      expect_lamps(PAT_SOLID, N, bp[k], br[k]);
    end
    drive(Y, Y, N, N, PROTO_LIN, CTRL_BUS_OFF, FR_NOT_INTEGRATED, Y);
    expect_lamps(PAT_SOLID, N, PAT_ACTIVITY, N);
  endtask : t_can

  // FlexRay has no idle timeout; halt needs prior integration
  task automatic t_flexray();
    drive(Y, Y, N, N, PROTO_FLEXRAY, CTRL_ERR_ACTIVE, FR_NORMAL_ACTIVE, N);
    expect_lamps(PAT_SOLID, N, PAT_ACTIVITY, N);
    drive(Y, Y, N, N, PROTO_FLEXRAY, CTRL_ERR_ACTIVE, FR_NORMAL_PASSIVE, N);
    expect_lamps(PAT_SOLID, N, PAT_ACTIVITY, Y);
    drive(Y, Y, N, N, PROTO_FLEXRAY, CTRL_ERR_ACTIVE, FR_HALT, N);
    expect_lamps(PAT_SOLID, N, PAT_SOLID, Y);
    drive(N, Y, N, N, PROTO_FLEXRAY, CTRL_ERR_ACTIVE, FR_HALT, N);
    drive(Y, Y, N, N, PROTO_FLEXRAY, CTRL_ERR_ACTIVE, FR_HALT, N);
    expect_lamps(PAT_SOLID, N, PAT_OFF, N);
    // Frames alone do not light a FlexRay port that is not integrated
    drive(Y, Y, N, N, PROTO_FLEXRAY, CTRL_ERR_ACTIVE, FR_NOT_INTEGRATED, Y);
    expect_lamps(PAT_SOLID, N, PAT_OFF, N);
  endtask : t_flexray

  // -------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    rst_i = Y;
    sess = N;
    pwr = N;
    ident = N;
    cat = N;
    frame = N;
    proto = PROTO_CAN;
    ctrl = CTRL_ERR_ACTIVE;
    fr = FR_NOT_INTEGRATED;
    repeat (10) @(posedge clk_i);
    rst_i <= N;
    @(posedge clk_i);
    #1;
    cmp_bit(|{s_red, s_grn, b_red, b_grn}, N);
    t_dark();
    t_override();
    t_power();
    t_timeout();
    t_can();
    t_flexray();
    cmp_bit(s_clash | b_clash, N);
    conclude();
  end

  // Whole run is near 900 cycles; stop a hang well beyond that
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule : tb
